// ---- core/drive_cmd_pkg.sv ----
// Contract
// - id byte: 0 unused, 1-12 and 199-200 defined, rest reserved or vendor
// - status flag bit 0 set if over-threshold is in warranty; 1-15 zero
// - current value is normalized into 01h..64h, low means near failure
// - attribute is normal only while its value is strictly above threshold
// - worst-so-far value and raw attribute data are kept per attribute
// - capability bit 0 set: save attribute data before entering power saving
// - capability bit 1 set: save data after prior operation; 2-15 zero
// - last block byte is two's complement of low byte sum of 511 bytes
// - flush cache writes every cached write to the media with full recovery
// - busy stays set during flush until all written or an error
// - flush cache not supported completes with abort set in error register
// - unrecoverable flush error ends command, loads address, drops sector
// - a later flush cache resumes flushing the data still cached
// - disable password takes 512 bytes; match clears user password and lock
// - master password stays intact when the user password is disabled
// - password mismatch completes disable password with aborted command
// - disable password aborts while locked or frozen
// - block word 0 bit 0 picks user/master, words 1-16 hold password
// - smart command with feature d0h returns the 512 byte attribute block
package drive_cmd_pkg;

   // register addresses on the host port
   localparam logic [3:0] A_DATA     = 4'h0;
   localparam logic [3:0] A_ERR_FEAT = 4'h1;
   localparam logic [3:0] A_LBA0     = 4'h3;
   localparam logic [3:0] A_LBA1     = 4'h4;
   localparam logic [3:0] A_LBA2     = 4'h5;
   localparam logic [3:0] A_DEV      = 4'h6;
   localparam logic [3:0] A_STAT_CMD = 4'h7;
   localparam logic [3:0] A_CTRL     = 4'h8;
   localparam logic [3:0] A_MPW      = 4'h9;
   localparam logic [3:0] A_UPW      = 4'ha;

   localparam logic [7:0] CMD_SMART       = 8'hb0;
   localparam logic [7:0] FEAT_READ_ATTR  = 8'hd0;
   localparam logic [7:0] CMD_FLUSH       = 8'he7;
   localparam logic [7:0] CMD_SEC_DISABLE = 8'hf6;

   // status, error and control bit positions
   localparam int ST_BSY   = 7;
   localparam int ST_DRDY  = 6;
   localparam int ST_DRQ   = 3;
   localparam int ST_ERR   = 0;
   localparam int ER_UNC   = 6;
   localparam int ER_ABRT  = 2;
   localparam int CT_FLUSH = 0;
   localparam int CT_CAPPW = 1;
   localparam int CT_CAPAU = 2;
   localparam int CT_LOCK  = 3;
   localparam int CT_FROZ  = 4;
   localparam logic [7:0] CTRL_RST = 8'h07;

   // 512 byte block layout
   localparam int          N_ATTR       = 30;
   localparam logic [8:0]  BLK_LAST     = 9'h1ff;
   localparam logic [8:0]  ATTR_FIRST   = 9'h002;
   localparam logic [8:0]  ATTR_END     = 9'h16a;
   localparam logic [8:0]  CAP_LO       = 9'h170;
   localparam logic [8:0]  PW_FIRST     = 9'h002;
   localparam logic [8:0]  PW_LAST      = 9'h021;
   localparam logic [8:0]  IDENT_BYTE   = 9'h000;
   localparam logic [3:0]  OFF_ID       = 4'h0;
   localparam logic [3:0]  OFF_FLAG     = 4'h1;
   localparam logic [3:0]  OFF_CUR      = 4'h3;
   localparam logic [3:0]  OFF_WORST    = 4'h4;
   localparam logic [3:0]  OFF_RAW0     = 4'h5;
   localparam logic [3:0]  OFF_RAW_LAST = 4'ha;
   localparam logic [3:0]  OFF_LAST     = 4'hb;
   localparam logic [15:0] FMT_VERSION  = 16'h0001;

   localparam logic [7:0]  NORM_MIN      = 8'h01;
   localparam logic [7:0]  NORM_MAX      = 8'h64;
   localparam logic [7:0]  THRESH_DEF    = 8'h0a;
   localparam logic [29:0] WARRANTY_MASK = 30'h0000_0fff;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_OUT   = 3'h1,
      ST_IN    = 3'h3,
      ST_CHECK = 3'h2,
      ST_FLUSH = 3'h6
   } state_t;

   typedef struct packed {
      logic [7:0]  cur;
      logic [7:0]  worst;
      logic [47:0] raw;
   } attr_t;

   typedef struct packed {
      logic        valid;
      logic [4:0]  idx;
      logic [7:0]  value;
      logic [47:0] raw;
   } attr_upd_t;

   typedef struct packed {
      logic        valid;
      logic [27:0] lba;
   } flush_err_t;

   function automatic logic [7:0] attr_id(input logic [4:0] i);
      case (i)
         5'h00:   return 8'h01;
         5'h01:   return 8'h02;
         5'h02:   return 8'h03;
         5'h03:   return 8'h04;
         5'h04:   return 8'h05;
         5'h05:   return 8'h07;
         5'h06:   return 8'h08;
         5'h07:   return 8'h09;
         5'h08:   return 8'h0a;
         5'h09:   return 8'h0c;
         5'h0a:   return 8'hc7;
         5'h0b:   return 8'hc8;
         default: return 8'h00;
      endcase
   endfunction

endpackage

// ---- core/attr_slot.sv ----
`timescale 1ns/10ps
module attr_slot #(
   parameter logic [4:0] IDX    = 5'h00,
   parameter logic [7:0] THRESH = 8'h0a
) (
   // clock and reset
   input  wire logic                    clock,
   input  wire logic                    srst,
   // update from the monitoring logic
   input  wire drive_cmd_pkg::attr_upd_t upd,
   // stored attribute
   output      drive_cmd_pkg::attr_t     data,
   output      logic                     ok
);
   import drive_cmd_pkg::*;

   logic [7:0] norm;

   always_comb begin
      norm = upd.value;
      if (upd.value < NORM_MIN)
         norm = NORM_MIN;
      else if (upd.value > NORM_MAX)
         norm = NORM_MAX;
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         data.cur   <= NORM_MAX;
         data.worst <= NORM_MAX;
         data.raw   <= '0;
      end else if (upd.valid && upd.idx == IDX) begin
         data.cur <= norm;
         data.raw <= upd.raw;
         if (norm < data.worst)
            data.worst <= norm;
      end
   end

   assign ok = data.cur > THRESH;

   a_cur_range: assert property (
      @(posedge clock) disable iff (srst)
      data.cur >= NORM_MIN && data.cur <= NORM_MAX)
      else $error("attribute value outside normalized range");

   a_worst_track: assert property (
      @(posedge clock) disable iff (srst)
      upd.valid && upd.idx == IDX |=>
         data.worst <= data.cur && data.worst <= $past(data.worst))
      else $error("worst value not tracking the lowest value");

endmodule

// ---- core/drive_cmd_core.sv ----
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/10ps
module drive_cmd_core (
   // clock and reset
   input  wire logic                      clock,
   input  wire logic                      srst,
   // host register port
   input  wire logic [3:0]                addr,
   input  wire logic [7:0]                wdata,
   input  wire logic                      wr,
   input  wire logic                      rd,
   output      logic [7:0]                rdata,
   // attribute monitoring
   input  wire drive_cmd_pkg::attr_upd_t  attr_upd,
   output      logic                      health_ok,
   // attribute save to medium
   input  wire logic                      pwr_save_req,
   input  wire logic                      op_done,
   input  wire logic                      save_done,
   output      logic                      save_req,
   output      logic                      pwr_save_ack,
   // write cache
   input  wire logic                      flush_done,
   input  wire drive_cmd_pkg::flush_err_t flush_err,
   output      logic                      flush_go,
   output      logic                      drop_sector,
   output      logic [27:0]               drop_lba
);
   import drive_cmd_pkg::*;

   state_t        state;
   state_t        next_state;
   logic          rej;
   logic [7:0]    feature;
   logic [27:0]   lba;
   logic          err;
   logic          abrt;
   logic          unc;
   logic          flush_sup;
   logic          cap_pwr;
   logic          cap_auto;
   logic          locked;
   logic          frozen;
   logic          upw_valid;
   logic [255:0]  user_pw;
   logic [255:0]  master_pw;
   logic [255:0]  pw_buf;
   logic          ident;
   logic [8:0]    bcnt;
   logic [4:0]    ent;
   logic [3:0]    off;
   logic [7:0]    sum;
   logic [7:0]    out_byte;
   logic [47:0]   raw_sh;
   logic          pw_match;
   logic          cmd_wr;
   logic          data_rd;
   logic          data_wr;
   logic          last_byte;
   logic          bsy;
   logic          drq;
   logic          save_busy;
   logic          pwr_pend;
   logic [7:0]    status;
   logic [7:0]    err_reg;
   attr_t         slot_q [N_ATTR];
   logic [N_ATTR-1:0] slot_ok;

   genvar g;
   generate
      for (g = 0; g < N_ATTR; g++) begin : g_slot
         attr_slot #(
            .IDX    (5'(g)),
            .THRESH (THRESH_DEF)
         ) u_slot (
            .clock (clock),
            .srst  (srst),
            .upd   (attr_upd),
            .data  (slot_q[g]),
            .ok    (slot_ok[g])
         );
      end
   endgenerate

   assign cmd_wr    = wr && addr == A_STAT_CMD && state == ST_IDLE;
   assign data_rd   = rd && addr == A_DATA && state == ST_OUT;
   assign data_wr   = wr && addr == A_DATA && state == ST_IN;
   assign last_byte = bcnt == BLK_LAST;
   assign bsy       = state == ST_FLUSH || state == ST_CHECK;
   assign drq       = state == ST_OUT || state == ST_IN;

   always_comb begin
      status         = 8'h00;
      status[ST_BSY] = bsy;
      status[ST_DRDY] = 1'b1;
      status[ST_DRQ] = drq;
      status[ST_ERR] = err;
      err_reg          = 8'h00;
      err_reg[ER_UNC]  = unc;
      err_reg[ER_ABRT] = abrt;
   end

   // identifier picks which stored password the block is held against
   always_comb begin
      if (ident)
         pw_match = pw_buf == master_pw;
      else
         pw_match = upw_valid && pw_buf == user_pw;
   end

   always_comb begin
      next_state = state;
      rej        = 1'b0;
      case (state)
         ST_IDLE: begin
            if (cmd_wr) begin
               case (wdata)
                  CMD_SMART: begin
                     if (feature == FEAT_READ_ATTR)
                        next_state = ST_OUT;
                     else
                        rej = 1'b1;
                  end
                  CMD_FLUSH: begin
                     if (flush_sup)
                        next_state = ST_FLUSH;
                     else
                        rej = 1'b1;
                  end
                  CMD_SEC_DISABLE: begin
                     if (locked || frozen)
                        rej = 1'b1;
                     else
                        next_state = ST_IN;
                  end
                  default: rej = 1'b1;
               endcase
            end
         end
         ST_OUT: begin
            if (data_rd && last_byte)
               next_state = ST_IDLE;
         end
         ST_IN: begin
            if (data_wr && last_byte)
               next_state = ST_CHECK;
         end
         ST_CHECK: begin
            next_state = ST_IDLE;
            rej        = !pw_match;
         end
         ST_FLUSH: begin
            if (flush_err.valid || flush_done)
               next_state = ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (srst)
         state <= ST_IDLE;
      else
         state <= next_state;
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         err  <= 1'b0;
         abrt <= 1'b0;
         unc  <= 1'b0;
      end else if (cmd_wr) begin
         err  <= rej;
         abrt <= rej;
         unc  <= 1'b0;
      end else if (state == ST_CHECK && rej) begin
         err  <= 1'b1;
         abrt <= 1'b1;
      end else if (state == ST_FLUSH && flush_err.valid) begin
         err <= 1'b1;
         unc <= 1'b1;
      end
   end

   // block byte generator for the attribute data stream
   always_comb begin
      raw_sh   = slot_q[ent].raw >> {off - OFF_RAW0, 3'h0};
      out_byte = 8'h00;
      if (last_byte)
         out_byte = 8'h00 - sum;
      else if (bcnt < ATTR_FIRST)
         out_byte = bcnt[0] ? FMT_VERSION[15:8] : FMT_VERSION[7:0];
      else if (bcnt < ATTR_END) begin
         case (off)
            OFF_ID:    out_byte = attr_id(ent);
            OFF_FLAG:  out_byte = {7'h00, WARRANTY_MASK[ent]};
            OFF_CUR:   out_byte = slot_q[ent].cur;
            OFF_WORST: out_byte = slot_q[ent].worst;
            default: begin
               if (off >= OFF_RAW0 && off <= OFF_RAW_LAST)
                  out_byte = raw_sh[7:0];
            end
         endcase
      end else if (bcnt == CAP_LO)
         out_byte = {6'h00, cap_auto, cap_pwr};
   end

   always_ff @(posedge clock) begin
      if (srst || cmd_wr) begin
         bcnt <= 9'h000;
         ent  <= 5'h00;
         off  <= 4'h0;
         sum  <= 8'h00;
      end else if (data_rd || data_wr) begin
         bcnt <= bcnt + 9'h001;
         if (bcnt >= ATTR_FIRST) begin
            if (off == OFF_LAST) begin
               off <= 4'h0;
               ent <= ent + 5'h01;
            end else
               off <= off + 4'h1;
         end
         if (data_rd)
            sum <= sum + out_byte;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         ident  <= 1'b0;
         pw_buf <= '0;
      end else if (data_wr) begin
         if (bcnt == IDENT_BYTE)
            ident <= wdata[0];
         if (bcnt >= PW_FIRST && bcnt <= PW_LAST)
            pw_buf <= {pw_buf[247:0], wdata};
      end
   end

   // security state survives between commands
   always_ff @(posedge clock) begin
      if (srst) begin
         locked    <= 1'b0;
         frozen    <= 1'b0;
         upw_valid <= 1'b0;
         user_pw   <= '0;
         master_pw <= '0;
      end else begin
         if (wr && addr == A_CTRL) begin
            locked <= wdata[CT_LOCK];
            frozen <= wdata[CT_FROZ];
         end
         if (wr && state == ST_IDLE && addr == A_MPW)
            master_pw <= {master_pw[247:0], wdata};
         if (wr && state == ST_IDLE && addr == A_UPW) begin
            user_pw   <= {user_pw[247:0], wdata};
            upw_valid <= 1'b1;
         end
         if (state == ST_CHECK && pw_match) begin
            upw_valid <= 1'b0;
            locked    <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         flush_sup <= CTRL_RST[CT_FLUSH];
         cap_pwr   <= CTRL_RST[CT_CAPPW];
         cap_auto  <= CTRL_RST[CT_CAPAU];
      end else if (wr && addr == A_CTRL) begin
         flush_sup <= wdata[CT_FLUSH];
         cap_pwr   <= wdata[CT_CAPPW];
         cap_auto  <= wdata[CT_CAPAU];
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         feature <= 8'h00;
         lba     <= '0;
      end else if (state == ST_FLUSH && flush_err.valid)
         lba <= flush_err.lba;
      else if (wr) begin
         case (addr)
            A_ERR_FEAT: feature     <= wdata;
            A_LBA0:     lba[7:0]    <= wdata;
            A_LBA1:     lba[15:8]   <= wdata;
            A_LBA2:     lba[23:16]  <= wdata;
            A_DEV:      lba[27:24]  <= wdata[3:0];
            default:    feature     <= feature;
         endcase
      end
   end

   // the media side resumes from whatever is still cached
   always_ff @(posedge clock) begin
      if (srst) begin
         flush_go    <= 1'b0;
         drop_sector <= 1'b0;
         drop_lba    <= '0;
      end else begin
         flush_go    <= next_state == ST_FLUSH;
         drop_sector <= state == ST_FLUSH && flush_err.valid;
         if (state == ST_FLUSH && flush_err.valid)
            drop_lba <= flush_err.lba;
      end
   end

   always_ff @(posedge clock) begin
      if (srst)
         rdata <= 8'h00;
      else if (rd) begin
         case (addr)
            A_DATA:     rdata <= data_rd ? out_byte : 8'h00;
            A_ERR_FEAT: rdata <= err_reg;
            A_LBA0:     rdata <= lba[7:0];
            A_LBA1:     rdata <= lba[15:8];
            A_LBA2:     rdata <= lba[23:16];
            A_DEV:      rdata <= {4'h0, lba[27:24]};
            A_STAT_CMD: rdata <= status;
            A_CTRL:
               rdata <= {3'h0, frozen, locked, cap_auto, cap_pwr, flush_sup};
            default:    rdata <= 8'h00;
         endcase
      end else
         rdata <= 8'h00;
   end

   always_ff @(posedge clock) begin
      if (srst)
         health_ok <= 1'b0;
      else
         health_ok <= &slot_ok;
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         save_req     <= 1'b0;
         pwr_save_ack <= 1'b0;
         save_busy    <= 1'b0;
         pwr_pend     <= 1'b0;
      end else begin
         save_req     <= 1'b0;
         pwr_save_ack <= 1'b0;
         if (save_busy && save_done) begin
            save_busy <= 1'b0;
            if (pwr_pend) begin
               pwr_pend     <= 1'b0;
               pwr_save_ack <= 1'b1;
            end
         end
         if (op_done && cap_auto && (!save_busy || save_done)) begin
            save_req  <= 1'b1;
            save_busy <= 1'b1;
         end
         if (pwr_save_req && !pwr_pend) begin
            if (cap_pwr) begin
               pwr_pend <= 1'b1;
               if (!save_busy || save_done) begin
                  save_req  <= 1'b1;
                  save_busy <= 1'b1;
               end
            end else
               pwr_save_ack <= 1'b1;
         end
      end
   end

   a_flush_busy: assert property (
      @(posedge clock) disable iff (srst)
      state == ST_FLUSH && !flush_done && !flush_err.valid |=>
         state == ST_FLUSH && flush_go)
      else $error("flush left busy before done or error");

   a_flush_abrt: assert property (
      @(posedge clock) disable iff (srst)
      cmd_wr && wdata == CMD_FLUSH && !flush_sup |=>
         err && abrt && state == ST_IDLE && !flush_go)
      else $error("unsupported flush not aborted");

   a_flush_drop: assert property (
      @(posedge clock) disable iff (srst)
      state == ST_FLUSH && flush_err.valid |=>
         drop_sector && drop_lba == $past(flush_err.lba) && unc
         && lba == $past(flush_err.lba))
      else $error("flush error not reported with failing address");

   a_pw_locked: assert property (
      @(posedge clock) disable iff (srst)
      cmd_wr && wdata == CMD_SEC_DISABLE && (locked || frozen) |=>
         state == ST_IDLE && abrt)
      else $error("disable password accepted while locked or frozen");

   a_master_kept: assert property (
      @(posedge clock) disable iff (srst)
      state == ST_CHECK |=> master_pw == $past(master_pw))
      else $error("master password changed by disable password");

   a_pw_result: assert property (
      @(posedge clock) disable iff (srst)
      state == ST_CHECK |=>
         (abrt && err) == !$past(pw_match) && (upw_valid == 1'b0 ||
         !$past(pw_match)))
      else $error("password compare outcome wrong");

   a_check_sum: assert property (
      @(posedge clock) disable iff (srst)
      data_rd && last_byte |=> rdata == 8'h00 - $past(sum)
         ##1 state == ST_IDLE)
      else $error("final block byte is not the checksum");

   a_smart_start: assert property (
      @(posedge clock) disable iff (srst)
      cmd_wr && wdata == CMD_SMART && feature == FEAT_READ_ATTR |=>
         state == ST_OUT && bcnt == 9'h000)
      else $error("attribute read did not start");

   a_save_first: assert property (
      @(posedge clock) disable iff (srst)
      pwr_save_req && cap_pwr && !save_busy && !pwr_pend |=>
         save_req && !pwr_save_ack)
      else $error("power save entered before attribute save");

endmodule

// ---- test/media_model.sv ----
`timescale 1ns/10ps
module media_model (
   // clock and reset
   input  wire logic                      clock,
   input  wire logic                      srst,
   // cache and save requests from the drive
   input  wire logic                      flush_go,
   input  wire logic                      save_req,
   // fault injection from the bench
   input  wire logic                      fail_en,
   input  wire logic [27:0]               fail_lba,
   // media answers
   output      logic                      flush_done,
   output      drive_cmd_pkg::flush_err_t flush_err,
   output      logic                      save_done,
   output      int                        left
);
   import drive_cmd_pkg::*;
   int save_cnt;

   // one sector written per cycle; idle lba toggles so stale data never holds
   always_ff @(posedge clock) begin
      flush_done <= 1'b0;
      flush_err  <= '{1'b0, srst ? 28'h0 : ~flush_err.lba};
      save_done  <= (save_cnt == 1);
      save_cnt   <= save_req ? 3 : (save_cnt > 0 ? save_cnt - 1 : 0);
      if (srst) begin
         left <= 40;
      end else if (flush_go && !flush_done && !flush_err.valid) begin
         if (fail_en && left == 30) begin
            flush_err <= '{1'b1, fail_lba};
            left      <= left - 1;
         end else if (left == 0) begin
            flush_done <= 1'b1;
         end else begin
            left <= left - 1;
         end
      end
   end
endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
   import drive_cmd_pkg::*;
   logic        clock, srst, wr, rd, pwr_save_req, op_done, save_done;
   logic        health_ok, save_req, pwr_save_ack, flush_done, flush_go;
   logic        drop_sector, fail_en;
   logic [3:0]  addr;
   logic [7:0]  wdata, rdata, q, sum;
   logic [27:0] drop_lba, fail_lba;
   logic [31:0] lba32;
   attr_upd_t   attr_upd;
   flush_err_t  flush_err;
   int          bad_count, num_checks, left, saves, drops, b, s0;
   logic [7:0]  cur [30], worst [30], blk [512], upw [32], mpw [32];
   logic [47:0] raw [30];
   logic [7:0]  ids [12] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07,
                             8'h08, 8'h09, 8'h0a, 8'h0c, 8'hc7, 8'hc8};

   drive_cmd_core dut_u (.clock(clock), .srst(srst), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .attr_upd(attr_upd),
      .health_ok(health_ok), .pwr_save_req(pwr_save_req),
      .op_done(op_done), .save_done(save_done), .save_req(save_req),
      .pwr_save_ack(pwr_save_ack), .flush_done(flush_done),
      .flush_err(flush_err), .flush_go(flush_go),
      .drop_sector(drop_sector), .drop_lba(drop_lba));
   media_model media_u (.clock(clock), .srst(srst), .flush_go(flush_go),
      .save_req(save_req), .fail_en(fail_en), .fail_lba(fail_lba),
      .flush_done(flush_done), .flush_err(flush_err),
      .save_done(save_done), .left(left));

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   always @(posedge clock) begin
      if (drop_sector) drops++;
      if (save_req) saves++;
   end

   task automatic chk(input logic [47:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one strobe cycle, then the cycle where read data stands
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
      addr  <= a;
      wdata <= d;
      wr    <= w;
      rd    <= !w;
      @(posedge clock);
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clock);
      q = rdata;
   endtask

   task automatic st(input logic [7:0] s, e);
      bus(1'b0, A_STAT_CMD, 8'h00);
      chk(q, s);
      bus(1'b0, A_ERR_FEAT, 8'h00);
      chk(q, e);
   endtask

   task automatic upd(input int i, input logic [7:0] v);
      raw[i] = {16'($urandom), 32'($urandom)};
      cur[i] = v < NORM_MIN ? NORM_MIN : v > NORM_MAX ? NORM_MAX : v;
      if (cur[i] < worst[i]) worst[i] = cur[i];
      attr_upd <= '{1'b1, 5'(i), v, raw[i]};
      @(posedge clock);
      attr_upd.valid <= 1'b0;
      repeat (3) @(posedge clock);
   endtask

   task automatic wait_go;
      for (int k = 0; k < 300 && flush_go; k++) @(posedge clock);
      chk(flush_go, 1'b0);
   endtask

   task automatic pwc(input logic [7:0] c, input logic id, bad, ab);
      bus(1'b1, A_CTRL, c);
      bus(1'b1, A_STAT_CMD, CMD_SEC_DISABLE);
      if (c == 8'h07)
         for (int i = 0; i < 512; i++)
            bus(1'b1, A_DATA, i == 0 ? {7'h0, id} : (i < 2 || i > 33) ? 8'h00
                : (id ? mpw[i-2] : upw[i-2]) ^ {7'h0, bad});
      st(ab ? 8'h41 : 8'h40, ab ? 8'h04 : 8'h00);
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      repeat (40000) @(posedge clock);
      bad_count++;
      results();
   end

   initial begin
      {srst, wr, rd, pwr_save_req, op_done, fail_en} = 6'b100000;
      {addr, wdata, fail_lba, sum} = '0;
      attr_upd = '0;
      void'($urandom(32'h55b6));
      for (int i = 0; i < 30; i++)
         {cur[i], worst[i], raw[i]} = {16'h6464, 48'h0};
      repeat (10) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      bus(1'b0, A_CTRL, 8'h00);
      chk(q, CTRL_RST);
      st(8'h40, 8'h00);
      bus(1'b0, 4'hb, 8'h00);
      chk(q, 8'h00);
      bus(1'b0, A_DATA, 8'h00);
      chk(q, 8'h00);
      bus(1'b1, A_STAT_CMD, CMD_SMART);
      st(8'h41, 8'h04);
      $display("reset test finished");
      for (int i = 0; i < 30; i++) upd(i, 8'($urandom_range(11, 100)));
      upd(3, 8'h0a);
      chk(health_ok, 1'b0);
      upd(3, 8'h0b);
      chk(health_ok, 1'b1);
      upd(7, 8'hc8);
      upd(8, 8'h00);
      chk(health_ok, 1'b0);
      bus(1'b1, A_ERR_FEAT, FEAT_READ_ATTR);
      bus(1'b1, A_STAT_CMD, CMD_SMART);
      st(8'h48, 8'h00);
      for (int i = 0; i < 512; i++) begin
         bus(1'b0, A_DATA, 8'h00);
         blk[i] = q;
         sum += q;
      end
      chk(sum, 8'h00);
      chk(blk[368], 8'h03);
      for (int n = 0; n < 30; n++) begin
         b = 2 + 12 * n;
         chk(blk[b], n < 12 ? ids[n] : 8'h00);
         chk({blk[b+2], blk[b+1]}, n < 12);
         chk(blk[b+3], cur[n]);
         chk(blk[b+4], worst[n]);
         for (int k = 0; k < 6; k++) chk(blk[b+5+k], raw[n][8*k+:8]);
      end
      st(8'h40, 8'h00);
      $display("attribute test finished");
      fail_en  <= 1'b1;
      fail_lba <= 28'($urandom);
      bus(1'b1, A_STAT_CMD, CMD_FLUSH);
      bus(1'b0, A_STAT_CMD, 8'h00);
      chk(q, 8'hc0);
      wait_go();
      st(8'h41, 8'h40);
      chk(drops, 1);
      chk(drop_lba, fail_lba);
      lba32 = {4'h0, fail_lba};
      for (int k = 0; k < 4; k++) begin
         bus(1'b0, 4'(A_LBA0 + k), 8'h00);
         chk(q & (k < 3 ? 8'hff : 8'h0f), lba32[8*k+:8]);
      end
      fail_en <= 1'b0;
      bus(1'b1, A_STAT_CMD, CMD_FLUSH);
      wait_go();
      st(8'h40, 8'h00);
      chk(left, 0);
      bus(1'b1, A_CTRL, 8'h06);
      bus(1'b1, A_STAT_CMD, CMD_FLUSH);
      chk(flush_go, 1'b0);
      st(8'h41, 8'h04);
      $display("flush test finished");
      for (int c = 3; c < 8; c += 2) begin
         bus(1'b1, A_CTRL, 8'(c));
         s0 = saves;
         pwr_save_req <= 1'b1;
         @(posedge clock);
         pwr_save_req <= 1'b0;
         for (int k = 0; k < 20 && !pwr_save_ack; k++) @(posedge clock);
         chk(pwr_save_ack, 1'b1);
         chk(saves - s0, c[1]);
         s0 = saves;
         op_done <= 1'b1;
         @(posedge clock);
         op_done <= 1'b0;
         repeat (8) @(posedge clock);
         chk(saves - s0, c[2]);
      end
      $display("save test finished");
      for (int i = 0; i < 32; i++) begin
         upw[i] = 8'($urandom);
         mpw[i] = 8'($urandom);
         bus(1'b1, A_UPW, upw[i]);
         bus(1'b1, A_MPW, mpw[i]);
      end
      pwc(8'h0f, 1'b0, 1'b0, 1'b1);
      pwc(8'h17, 1'b0, 1'b0, 1'b1);
      pwc(8'h07, 1'b0, 1'b1, 1'b1);
      pwc(8'h07, 1'b0, 1'b0, 1'b0);
      pwc(8'h07, 1'b0, 1'b0, 1'b1);
      pwc(8'h07, 1'b1, 1'b0, 1'b0);
      $display("password test finished");
      results();
   end
endmodule
